// ==== test/rrts_testbench.sv ====
// Self-checking bench for the round robin task sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rrts_consts.svh"
module testbench;
  import rrts_pkg::*;
  localparam int N = `RRTS_NUM_TASKS;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [N-1:0] i_entry_defined = 4'hF;
  logic [N*`RRTS_PC_W-1:0] i_entry_pc = '0;
  logic [N-1:0] i_task_idle = 4'h0;
  logic i_irq = 1'b0;
  logic i_irq_done = 1'b0;
  rrts_retire_type i_retire = '0;
  rrts_issue_type o_issue;
  logic o_parallel;
  logic o_irq_active;
  logic [`RRTS_TASK_W-1:0] o_cur_task;
  logic [N-1:0] o_suspended;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 65;
  int cur, nxt, k, t;
  int op, ipc, tg;
  int pcm [N];
  int stk_m [N][`RRTS_STACK_DEPTH];
  int sp_m [N];
  bit hung = 1'b0;
  logic [N-1:0] susp;
  bit par_m;

  always #20 i_clk_sys = ~i_clk_sys;

  rrts_seq #(.N(N)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_entry_defined(i_entry_defined), .i_entry_pc(i_entry_pc), .i_task_idle(i_task_idle),
    .i_irq(i_irq), .i_irq_done(i_irq_done), .i_retire(i_retire), .o_issue(o_issue),
    .o_parallel(o_parallel), .o_irq_active(o_irq_active), .o_cur_task(o_cur_task),
    .o_suspended(o_suspended));

  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  // Next eligible defined task after c; sequential mode only ever runs task 0
  function automatic int pick(input int c);
    int j;
    if (!par_m) return 0;
    for (int i = 1; i <= N; i++) begin
      j = (c + i) % N;
      if ((i_entry_defined[j] || j == 0) && !susp[j] && !i_task_idle[j]) return j;
    end
    return -1;
  endfunction

  task automatic do_reset(input logic [N-1:0] defs);
    i_rst = 1'b1;
    i_entry_defined = defs;
    i_task_idle = 4'h0;
    par_m = $countones(defs | 4'h1) >= 2;
    susp = 4'h0;
    for (int i = 0; i < N; i++) begin
      k = $random(seed);
      // Any 12-bit entry lies inside program memory
      i_entry_pc[i*12+:12] = k[11:0];
      pcm[i] = (i == 0) ? 0 : k[11:0];
      sp_m[i] = 0;
    end
    repeat (6) @(negedge i_clk_sys);
    chk("valid_in_reset", 16'h0, 16'(o_issue.valid));
    i_rst = 1'b0;
    cur = N - 1;
  endtask

  task automatic run(input int n);
    for (int it = 0; it < n && !hung; it++) begin
      nxt = pick(cur);
      t = 0;
      while (o_issue.valid !== 1'b1 && t < 20) begin
        @(negedge i_clk_sys);
        t++;
      end
      if (t == 20) begin
        chk("issue_wait", 16'h1, 16'(o_issue.valid));
        hung = 1'b1;
        return;
      end
      chk("task_id", 16'(nxt), 16'(o_issue.task_id));
      chk("pc", 16'(pcm[nxt]), 16'(o_issue.pc));
      chk("cur_task", 16'(nxt), 16'(o_cur_task));
      chk("parallel", 16'(par_m), 16'(o_parallel));
      cur = nxt;
      k = $random(seed);
      op = k[17:16];
      ipc = pcm[cur];
      i_retire = '0;
      i_retire.done = 1'b1;
      i_retire.next_pc = k[11:0];
      pcm[cur] = k[11:0];
      // Calls outnumber returns so stacks fill and refuse pushes
      if (op == 1 || op == 3) begin
        i_retire.call = 1'b1;
        if (sp_m[cur] < `RRTS_STACK_DEPTH) begin
          stk_m[cur][sp_m[cur]] = (ipc + 1) % 4096;
          sp_m[cur]++;
        end
      end else if (op == 2) begin
        i_retire.ret = 1'b1;
        if (sp_m[cur] > 0) begin
          sp_m[cur]--;
          pcm[cur] = stk_m[cur][sp_m[cur]];
        end
      end
      // Random idle bits never include task 0 so the rotation can never run dry
      i_task_idle = k[15:12] & 4'hE;
      if (it % 9 == 2) begin
        tg = k[21:20];
        i_retire.restart = 1'b1;
        i_retire.target = 2'(tg);
        pcm[tg] = (tg == 0) ? 0 : i_entry_pc[tg*12+:12];
        sp_m[tg] = 0;
      end else if (par_m && it % 9 == 4) begin
        i_retire.suspend = 1'b1;
        i_retire.target = 2'h3;
        susp[3] = 1'b1;
      end else if (it % 9 == 7 && susp[3]) begin
        i_retire.resume = 1'b1;
        i_retire.target = 2'h3;
        susp[3] = 1'b0;
      end else if (it % 9 == 8) begin
        // A task may not resume itself; flags stay as they are
        i_retire.resume = 1'b1;
        i_retire.target = 2'(cur);
      end
      i_irq = (it % 10 == 5);
      @(negedge i_clk_sys);
      i_retire = '0;
      chk("gap_valid", 16'h0, 16'(o_issue.valid));
      chk("irq_idle", 16'h0, 16'(o_irq_active));
      chk("suspended", 16'(susp), 16'(o_suspended));
      if (it % 10 == 8) begin
        // Every task in a delay: nothing may issue
        i_task_idle = 4'hF;
        repeat (3) @(negedge i_clk_sys);
        chk("dry_valid", 16'h0, 16'(o_issue.valid));
        i_task_idle = k[15:12] & 4'hE;
      end
      if (i_irq) begin
        t = 0;
        while (o_irq_active !== 1'b1 && t < 10) begin
          @(negedge i_clk_sys);
          t++;
        end
        if (t == 10) begin
          chk("irq_wait", 16'h1, 16'(o_irq_active));
          hung = 1'b1;
          return;
        end
        chk("irq_active", 16'h1, 16'(o_irq_active));
        chk("irq_blocks_issue", 16'h0, 16'(o_issue.valid));
        i_irq = 1'b0;
        i_irq_done = 1'b1;
        @(negedge i_clk_sys);
        i_irq_done = 1'b0;
      end
    end
  endtask

  initial begin
    do_reset(4'hF);
    run(60);
    do_reset(4'h1);
    run(8);
    do_reset(4'h5);
    run(20);
    summarize();
  end
endmodule
`default_nettype wire

// ==== verilog/rrts_consts.svh ====
// Constants for the round robin task sequencer
`ifndef RRTS_CONSTS_SVH
`define RRTS_CONSTS_SVH
`define RRTS_NUM_TASKS 4
`define RRTS_TASK_W 2
`define RRTS_PC_W 12
`define RRTS_STACK_DEPTH 4
`define RRTS_SP_W 3
`define RRTS_PAR_MIN_ENTRIES 2
`define RRTS_TASK0_ENTRY 12'h000
`define RRTS_IRQ_VECTOR 12'hFF0
`endif

// ==== verilog/rrts_pick.sv ====
// Round robin picker: next eligible task after the current one
`timescale 1ns/1ps
`default_nettype none
`include "rrts_consts.svh"
module rrts_pick
  import rrts_pkg::*;
#(
  parameter int N = `RRTS_NUM_TASKS,
  parameter int W = `RRTS_TASK_W
) (
  input wire logic [N-1:0] i_eligible,
  input wire logic [W-1:0] i_cur,
  output logic o_found,
  output logic [W-1:0] o_next
);
  always_comb begin
    o_found = 1'b0;
    o_next = i_cur;
    // Search from cur+1 wrapping back to cur itself
    for (int k = 1; k <= N; k++) begin
      if (!o_found && i_eligible[W'((32'(i_cur) + k) % N)]) begin
        o_found = 1'b1;
        o_next = W'((32'(i_cur) + k) % N);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/rrts_pkg.sv ====
// Types for the round robin task sequencer
`include "rrts_consts.svh"
package rrts_pkg;
  typedef enum logic [2:0] {
    RRTS_ST_IDLE = 3'b001,
    RRTS_ST_RUN = 3'b010,
    RRTS_ST_IRQ = 3'b100
  } rrts_state_type;

  // Issued command slot toward the core
  typedef struct packed {
    logic valid;
    logic [`RRTS_TASK_W-1:0] task_id;
    logic [`RRTS_PC_W-1:0] pc;
  } rrts_issue_type;

  // Result reported by the core for the last issued command
  typedef struct packed {
    logic done;
    logic [`RRTS_PC_W-1:0] next_pc;
    logic call;
    logic ret;
    logic suspend;
    logic resume;
    logic restart;
    logic [`RRTS_TASK_W-1:0] target;
  } rrts_retire_type;
endpackage

// ==== verilog/rrts_seq.sv ====
// Round robin task sequencer top level
// Summary of operation
// - Single-task mode or parallel interleaved mode
// - Two entries select parallel; reset starts all
// - Commands issued round robin across tasks
// - Idle tasks skipped without spending a slot
// - Data memory shared equally by all tasks
// - Task 0 starts at memory start first
// - Extra tasks entered by their own index
// - Own program counter and stack per task
// - Single interrupt preempts every running task
// - Current task index readable, updated each switch
// - Suspend per task; resume only from another
`timescale 1ns/1ps
`default_nettype none
`include "rrts_consts.svh"
module rrts_seq
  import rrts_pkg::*;
#(
  parameter int N = `RRTS_NUM_TASKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [N-1:0] i_entry_defined,
  input wire logic [N*`RRTS_PC_W-1:0] i_entry_pc,
  input wire logic [N-1:0] i_task_idle,
  input wire logic i_irq,
  input wire logic i_irq_done,
  input wire rrts_retire_type i_retire,
  output rrts_issue_type o_issue,
  output logic o_parallel,
  output logic o_irq_active,
  output logic [`RRTS_TASK_W-1:0] o_cur_task,
  output logic [N-1:0] o_suspended
);
  localparam int PW = `RRTS_PC_W;
  localparam int TW = `RRTS_TASK_W;
  localparam int SD = `RRTS_STACK_DEPTH;
  localparam int SW = `RRTS_SP_W;

  typedef struct packed {
    rrts_state_type st;
    logic parallel;
    logic [TW-1:0] cur;
    logic [N-1:0] susp;
    logic [N-1:0][PW-1:0] pc;
    logic [N-1:0][SD-1:0][PW-1:0] stk;
    logic [N-1:0][SW-1:0] sp;
    rrts_issue_type issue;
  } rrts_core_type;

  rrts_core_type s_r, s_nxt;
  logic [N-1:0] eligible;
  logic found;
  logic [TW-1:0] nxt_task;
  logic [TW-1:0] wait_task;

  // Defined, not suspended, not in a delay
  always_comb begin
    eligible = i_entry_defined & ~s_r.susp & ~i_task_idle;
    // Task 0 always exists
    eligible[0] = ~s_r.susp[0] & ~i_task_idle[0];
  end

  rrts_pick #(.N(N), .W(TW)) u_pick (
    .i_eligible(eligible),
    .i_cur(s_r.cur),
    .o_found(found),
    .o_next(nxt_task)
  );

  assign wait_task = s_r.issue.task_id;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      RRTS_ST_IDLE: begin
        // Launch all defined tasks at their entry points
        s_nxt.parallel = ($countones(i_entry_defined | N'(1)) >= `RRTS_PAR_MIN_ENTRIES);
        for (int t = 0; t < N; t++) begin
          s_nxt.pc[t] = i_entry_pc[t*PW +: PW];
          s_nxt.sp[t] = '0;
        end
        s_nxt.pc[0] = `RRTS_TASK0_ENTRY;
        s_nxt.susp = '0;
        s_nxt.cur = TW'(N - 1);
        s_nxt.issue = '0;
        s_nxt.st = RRTS_ST_RUN;
      end
      RRTS_ST_RUN: begin
        if (s_r.issue.valid) begin
          // One command in flight; retire before the next
          if (i_retire.done) begin
            s_nxt.issue.valid = 1'b0;
            s_nxt.pc[wait_task] = i_retire.next_pc;
            // Full stack drops the push; the core still takes next_pc
            if (i_retire.call && s_r.sp[wait_task] < SW'(SD)) begin
              s_nxt.stk[wait_task][s_r.sp[wait_task][SW-2:0]] = s_r.issue.pc + PW'(1);
              s_nxt.sp[wait_task] = s_r.sp[wait_task] + SW'(1);
            end else if (i_retire.ret && s_r.sp[wait_task] != '0) begin
              s_nxt.pc[wait_task] = s_r.stk[wait_task][s_r.sp[wait_task][SW-2:0] - 1'b1];
              s_nxt.sp[wait_task] = s_r.sp[wait_task] - SW'(1);
            end
            // Resume only from a different task
            if (i_retire.suspend) begin
              s_nxt.susp[i_retire.target] = 1'b1;
            end else if (i_retire.resume && i_retire.target != wait_task) begin
              s_nxt.susp[i_retire.target] = 1'b0;
            end
            if (i_retire.restart) begin
              s_nxt.pc[i_retire.target] = (i_retire.target == '0) ?
                `RRTS_TASK0_ENTRY : i_entry_pc[32'(i_retire.target)*PW +: PW];
              s_nxt.sp[i_retire.target] = '0;
            end
          end
        end else if (i_irq) begin
          // One interrupt holds off every task
          s_nxt.st = RRTS_ST_IRQ;
        end else if (!s_r.parallel) begin
          // Sequential mode runs task 0 only
          if (eligible[0]) begin
            s_nxt.cur = '0;
            s_nxt.issue = '{valid: 1'b1, task_id: '0, pc: s_r.pc[0]};
          end
        end else if (found) begin
          // Switch and issue in the same cycle
          s_nxt.cur = nxt_task;
          s_nxt.issue = '{valid: 1'b1, task_id: nxt_task, pc: s_r.pc[nxt_task]};
        end
      end
      RRTS_ST_IRQ: begin
        if (i_irq_done) begin
          s_nxt.st = RRTS_ST_RUN;
        end
      end
      default: s_nxt.st = RRTS_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.st <= RRTS_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data memory lives outside and is shared; no per-task banking
  assign o_issue = s_r.issue;
  assign o_parallel = s_r.parallel;
  assign o_irq_active = (s_r.st == RRTS_ST_IRQ);
  assign o_cur_task = s_r.cur;
  assign o_suspended = s_r.susp;

  AST_ONE_INFLIGHT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && !i_retire.done |=> s_r.issue.valid && $stable(s_r.issue.task_id))
    else $error("issue dropped before retire");
  AST_RR_ORDER: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(s_r.issue.valid) && s_r.parallel && found |-> s_r.issue.task_id == $past(nxt_task))
    else $error("issue not from picker");
  AST_NO_SUSP_ISSUE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !s_r.issue.valid && !i_irq && s_r.st == RRTS_ST_RUN && eligible == '0
    |=> !s_r.issue.valid)
    else $error("issued with nothing eligible");
  AST_IDLE_SKIP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st == RRTS_ST_RUN && !s_r.issue.valid && !i_irq && s_r.parallel && found
    |-> !i_task_idle[nxt_task] ##1 s_r.issue.valid)
    else $error("idle task took a slot");
  AST_IRQ_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st == RRTS_ST_IRQ |=> !s_r.issue.valid)
    else $error("issue during interrupt");
  AST_CUR_TRACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(s_r.issue.valid) |-> o_cur_task == s_r.issue.task_id)
    else $error("current task not updated");
  AST_TASK0_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st == RRTS_ST_IDLE |=> s_r.pc[0] == `RRTS_TASK0_ENTRY)
    else $error("task 0 entry wrong");
  AST_SEQ_ONLY0: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && !s_r.parallel |-> s_r.issue.task_id == '0)
    else $error("sequential mode issued other task");
  AST_SELF_RESUME: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.resume && !i_retire.suspend
    && i_retire.target == s_r.issue.task_id |=> s_r.susp == $past(s_r.susp))
    else $error("task resumed itself");
  AST_SUSPEND_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.suspend
    |=> s_r.susp[$past(i_retire.target)])
    else $error("suspend not applied");
  AST_NO_SUSP_RISE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(s_r.issue.valid) |-> !s_r.susp[s_r.issue.task_id])
    else $error("suspended task issued");

  // Per-task program counter and return stack bookkeeping
  AST_PC_RETIRE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && !i_retire.ret && !i_retire.restart
    |=> s_r.pc[$past(wait_task)] == $past(i_retire.next_pc))
    else $error("retired pc not stored");
  AST_CALL_PUSH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.call && !i_retire.restart
    && s_r.sp[wait_task] < SW'(SD)
    |=> s_r.sp[$past(wait_task)] == $past(s_r.sp[wait_task]) + SW'(1)
    && s_r.stk[$past(wait_task)][$past(s_r.sp[wait_task][SW-2:0])]
    == $past(s_r.issue.pc) + PW'(1))
    else $error("call did not push return address");
  AST_CALL_FULL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.call && !i_retire.restart
    && s_r.sp[wait_task] == SW'(SD) |=> s_r.sp[$past(wait_task)] == SW'(SD))
    else $error("push into full stack");
  AST_RET_POP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.ret && !i_retire.call && !i_retire.restart
    && s_r.sp[wait_task] != '0
    |=> s_r.sp[$past(wait_task)] == $past(s_r.sp[wait_task]) - SW'(1))
    else $error("return did not pop stack");
  AST_RET_EMPTY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.ret && !i_retire.call && !i_retire.restart
    && s_r.sp[wait_task] == '0 |=> s_r.pc[$past(wait_task)] == $past(i_retire.next_pc))
    else $error("empty return not taken from next pc");
  AST_RESTART_ENTRY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.issue.valid && i_retire.done && i_retire.restart && i_retire.target == '0
    |=> s_r.pc[0] == `RRTS_TASK0_ENTRY && s_r.sp[0] == '0)
    else $error("task 0 restart entry wrong");

  // Interrupt entry and exit around the rotation; mode held after launch
  AST_IRQ_ENTER: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st == RRTS_ST_RUN && !s_r.issue.valid && i_irq
    |=> s_r.st == RRTS_ST_IRQ && !s_r.issue.valid)
    else $error("interrupt not taken");
  AST_IRQ_LEAVE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st == RRTS_ST_IRQ && i_irq_done |=> s_r.st == RRTS_ST_RUN)
    else $error("interrupt not left");
  AST_MODE_STABLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_r.st != RRTS_ST_IDLE |=> $stable(s_r.parallel))
    else $error("mode changed after launch");
endmodule
`default_nettype wire
